// ---- rtl/jbd_top.sv ----
// Function
// - Debug byte register, write sets dirty flag
// - Read gives seven low bits, dirty on top
// - Shared address routed only with fuse, grant
// - Port enabled by fuse and clear disable
// - Lock bits block debug fuse until erase
// - Program fuses and locks, lock protection kept
// - Identification instruction current after power-up
// - Pin outputs float in reset, reset pin seen two mclk cycles late
// - Reset from pin or reset register
// - EXTEST drives output latches onto pins
// - SAMPLE snapshots pins, operation undisturbed
// - Boundary scan runs on test clock alone
// - BYPASS gives one-stage path
// - Four data registers selectable
// - Chain covers pins and analog boundary
// - Four-bit instructions with fixed opcodes
// - Bypass stage captures zero
// - Reset register holds reset, unlatched
// - Shift registers move LSB first
`timescale 1ns/10ps
module jbd_top (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdoOe,
  input  wire logic                      extResetN,
  input  wire logic                      testPortEnableFuse,
  input  wire logic                      testPortDisableBit,
  input  wire jbd_pkg::jbd_io_req_t      ioReq,
  output logic      [jbd_pkg::DB_W-1:0]  ioRdata,
  output logic                           stdIoWr,
  output logic                           stdIoRd,
  output logic      [jbd_pkg::DB_W-1:0]  stdIoWdata,
  input  wire jbd_pkg::jbd_prog_t        prog,
  output logic                           debugEnableFuse,
  output logic                           lockBitOne,
  output logic                           lockBitTwo,
  input  wire logic                      dbgGrant,
  input  wire logic                      dbgClearDirty,
  output logic      [jbd_pkg::DB_W-1:0]  dbgByte,
  output logic                           dbgDirty,
  input  wire jbd_pkg::jbd_pins_t        core,
  input  wire logic [jbd_pkg::PINS-1:0]  pinIn,
  output logic      [jbd_pkg::PINS-1:0]  pinOut,
  output logic      [jbd_pkg::PINS-1:0]  pinOe,
  output logic      [jbd_pkg::ANA-1:0]   anaOut,
  output logic                           chipReset
);

  typedef struct packed {
    logic [jbd_pkg::DB_W-1:0] dbyte;
    logic                     dirty;
    logic [jbd_pkg::DB_W-1:0] rdata;
    logic                     stdWr;
    logic                     stdRd;
    logic [jbd_pkg::DB_W-1:0] stdWdata;
    logic                     clrSeen;
    logic                     dbgFuse;
    logic                     lock1;
    logic                     lock2;
  } jbd_mst_t;

  typedef struct packed {
    jbd_pkg::jbd_tap_t        state;
    logic [3:0]               ir;
    logic [3:0]               irSh;
    logic                     byp;
    logic [jbd_pkg::ID_W-1:0] idSh;
    logic                     rstReg;
    logic                     tdoOe;
    logic                     clrTgl;
    logic [jbd_pkg::DB_W-1:0] dbyte;
    logic                     dirty;
  } jbd_tst_t;

  jbd_mst_t m_q;
  jbd_mst_t m_d;
  jbd_tst_t t_q;
  jbd_tst_t t_d;

  jbd_pkg::jbd_m2t_t m2tIn;
  jbd_pkg::jbd_m2t_t m2t;
  jbd_pkg::jbd_t2m_t t2mIn;
  jbd_pkg::jbd_t2m_t t2m;

  logic                       tRst;
  logic                       bsSel;
  logic                       bsSo;
  logic [jbd_pkg::BS_LEN-1:0] bsUpd;
  logic [jbd_pkg::BS_LEN-1:0] capVec;
  logic                       extest;
  logic                       dbgRoute;

  // Capture vector: per pin input, output data, output control
  always_comb begin
    capVec = '0;
    for (int i = 0; i < jbd_pkg::PINS; i++) begin
      capVec[i*jbd_pkg::PIN_CELLS+jbd_pkg::CELL_IN]   = pinIn[i];
      capVec[i*jbd_pkg::PIN_CELLS+jbd_pkg::CELL_OUT]  = core.out[i];
      capVec[i*jbd_pkg::PIN_CELLS+jbd_pkg::CELL_CTRL] = core.oe[i];
    end
    for (int k = 0; k < jbd_pkg::ANA; k++) begin
      capVec[jbd_pkg::ANA_BASE+k] = core.ana[k];
    end
  end

  assign m2tIn.rst     = rst;
  assign m2tIn.portEn  = testPortEnableFuse;
  assign m2tIn.portDis = testPortDisableBit;
  assign m2tIn.dirty   = m_q.dirty;
  assign m2tIn.dbyte   = m_q.dbyte;
  assign m2tIn.cap     = capVec;

  assign t2mIn.clrTgl  = t_q.clrTgl;
  assign t2mIn.grant   = dbgGrant;
  assign t2mIn.extRstN = extResetN;

  jbd_sync #(
    .W ($bits(jbd_pkg::jbd_m2t_t))
  ) u_sync_m2t (
    .clk (tck),
    .d   (m2tIn),
    .q   (m2t)
  );

  jbd_sync #(
    .W ($bits(jbd_pkg::jbd_t2m_t))
  ) u_sync_t2m (
    .clk (mclk),
    .d   (t2mIn),
    .q   (t2m)
  );

  // ---------------- Main clock domain ----------------
  assign dbgRoute = ioReq.sel & m_q.dbgFuse & t2m.grant;

  always_comb begin
    m_d       = m_q;
    m_d.stdWr = 1'b0;
    m_d.stdRd = 1'b0;
    if (t2m.clrTgl != m_q.clrSeen) begin
      m_d.clrSeen = t2m.clrTgl;
      m_d.dirty   = 1'b0;
    end
    if (dbgRoute) begin
      if (ioReq.wr) begin
        m_d.dbyte = ioReq.wdata;
        m_d.dirty = 1'b1;
      end
      if (ioReq.rd) begin
        m_d.rdata = {m_q.dirty, m_q.dbyte[jbd_pkg::DIRTY_BIT-1:0]};
      end
    end else if (ioReq.sel) begin
      m_d.stdWr    = ioReq.wr;
      m_d.stdRd    = ioReq.rd;
      m_d.stdWdata = ioReq.wdata;
    end
    // Fuse and lock store, locks cleared only by erase or reset
    if (prog.erase) begin
      m_d.lock1 = 1'b0;
      m_d.lock2 = 1'b0;
    end else if (prog.req) begin
      if (prog.target == jbd_pkg::PROG_DBGFUSE) begin
        if (!prog.value || !(m_q.lock1 || m_q.lock2)) begin
          m_d.dbgFuse = prog.value;
        end
      end else if (prog.target == jbd_pkg::PROG_LOCK1) begin
        m_d.lock1 = m_q.lock1 | prog.value;
      end else if (prog.target == jbd_pkg::PROG_LOCK2) begin
        m_d.lock2 = m_q.lock2 | prog.value;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      m_q          <= '0;
      m_q.dbyte    <= jbd_pkg::DB_RESET;
      m_q.dbgFuse  <= jbd_pkg::NV_RESET;
      m_q.lock1    <= jbd_pkg::NV_RESET;
      m_q.lock2    <= jbd_pkg::NV_RESET;
    end else begin
      m_q <= m_d;
    end
  end

  assign ioRdata         = m_q.rdata;
  assign stdIoWr         = m_q.stdWr;
  assign stdIoRd         = m_q.stdRd;
  assign stdIoWdata      = m_q.stdWdata;
  assign debugEnableFuse = m_q.dbgFuse;
  assign lockBitOne      = m_q.lock1;
  assign lockBitTwo      = m_q.lock2;

  // ---------------- Test clock domain ----------------
  // Port held in reset unless fuse set and disable clear
  assign tRst = m2t.rst | ~m2t.portEn | m2t.portDis;

  assign bsSel = (t_q.ir == jbd_pkg::OP_EXTEST) ||
                 (t_q.ir == jbd_pkg::OP_SAMPLE);

  always_comb begin
    t_d        = t_q;
    t_d.dbyte  = m2t.dbyte;
    t_d.dirty  = m2t.dirty;
    t_d.clrTgl = t_q.clrTgl ^ dbgClearDirty;
    case (t_q.state)
      jbd_pkg::TLR:    t_d.state = tms ? jbd_pkg::TLR    : jbd_pkg::RTI;
      jbd_pkg::RTI:    t_d.state = tms ? jbd_pkg::SEL_DR : jbd_pkg::RTI;
      jbd_pkg::SEL_DR: t_d.state = tms ? jbd_pkg::SEL_IR : jbd_pkg::CAP_DR;
      jbd_pkg::CAP_DR: t_d.state = tms ? jbd_pkg::EX1_DR : jbd_pkg::SH_DR;
      jbd_pkg::SH_DR:  t_d.state = tms ? jbd_pkg::EX1_DR : jbd_pkg::SH_DR;
      jbd_pkg::EX1_DR: t_d.state = tms ? jbd_pkg::UPD_DR : jbd_pkg::PA_DR;
      jbd_pkg::PA_DR:  t_d.state = tms ? jbd_pkg::EX2_DR : jbd_pkg::PA_DR;
      jbd_pkg::EX2_DR: t_d.state = tms ? jbd_pkg::UPD_DR : jbd_pkg::SH_DR;
      jbd_pkg::UPD_DR: t_d.state = tms ? jbd_pkg::SEL_DR : jbd_pkg::RTI;
      jbd_pkg::SEL_IR: t_d.state = tms ? jbd_pkg::TLR    : jbd_pkg::CAP_IR;
      jbd_pkg::CAP_IR: t_d.state = tms ? jbd_pkg::EX1_IR : jbd_pkg::SH_IR;
      jbd_pkg::SH_IR:  t_d.state = tms ? jbd_pkg::EX1_IR : jbd_pkg::SH_IR;
      jbd_pkg::EX1_IR: t_d.state = tms ? jbd_pkg::UPD_IR : jbd_pkg::PA_IR;
      jbd_pkg::PA_IR:  t_d.state = tms ? jbd_pkg::EX2_IR : jbd_pkg::PA_IR;
      jbd_pkg::EX2_IR: t_d.state = tms ? jbd_pkg::UPD_IR : jbd_pkg::SH_IR;
      jbd_pkg::UPD_IR: t_d.state = tms ? jbd_pkg::SEL_DR : jbd_pkg::RTI;
      default:         t_d.state = jbd_pkg::TLR;
    endcase
    case (t_q.state)
      jbd_pkg::TLR: begin
        t_d.ir     = jbd_pkg::OP_IDCODE;
        t_d.rstReg = 1'b0;
      end
      jbd_pkg::CAP_IR: t_d.irSh = jbd_pkg::IR_CAPTURE;
      jbd_pkg::SH_IR:  t_d.irSh = {tdi, t_q.irSh[3:1]};
      jbd_pkg::UPD_IR: t_d.ir   = t_q.irSh;
      jbd_pkg::CAP_DR: begin
        t_d.byp  = 1'b0;
        t_d.idSh = {jbd_pkg::ID_VERSION, jbd_pkg::ID_PART,
                    jbd_pkg::ID_MANUF, jbd_pkg::ID_MARKER};
      end
      jbd_pkg::SH_DR: begin
        if (t_q.ir == jbd_pkg::OP_IDCODE) begin
          t_d.idSh = {tdi, t_q.idSh[jbd_pkg::ID_W-1:1]};
        end else if (t_q.ir == jbd_pkg::OP_CHIPRST) begin
          t_d.rstReg = tdi;
        end else if (!bsSel) begin
          t_d.byp = tdi;
        end
      end
      default: t_d.byp = t_q.byp;
    endcase
    t_d.tdoOe = (t_d.state == jbd_pkg::SH_DR) ||
                (t_d.state == jbd_pkg::SH_IR);
  end

  always_ff @(posedge tck) begin
    if (tRst) begin
      t_q       <= '0;
      t_q.state <= jbd_pkg::TLR;
      t_q.ir    <= jbd_pkg::OP_IDCODE;
      t_q.clrTgl <= m2t.rst ? 1'b0 : t_q.clrTgl;
    end else begin
      t_q <= t_d;
    end
  end

  // Runs on tck alone, no main clock involved
  jbd_bscan #(
    .LEN (jbd_pkg::BS_LEN)
  ) u_bscan (
    .tck     (tck),
    .rst     (tRst),
    .capture (bsSel && t_q.state == jbd_pkg::CAP_DR),
    .shift   (bsSel && t_q.state == jbd_pkg::SH_DR),
    .update  (bsSel && t_q.state == jbd_pkg::UPD_DR),
    .tdi     (tdi),
    .capData (m2t.cap),
    .so      (bsSo),
    .upd     (bsUpd)
  );

  // Output path selection
  always_comb begin
    if (t_q.state == jbd_pkg::SH_IR) begin
      tdo = t_q.irSh[0];
    end else if (t_q.ir == jbd_pkg::OP_IDCODE) begin
      tdo = t_q.idSh[0];
    end else if (t_q.ir == jbd_pkg::OP_CHIPRST) begin
      tdo = t_q.rstReg;
    end else if (bsSel) begin
      tdo = bsSo;
    end else begin
      tdo = t_q.byp;
    end
  end

  assign tdoOe    = t_q.tdoOe;
  assign dbgByte  = t_q.dbyte;
  assign dbgDirty = t_q.dirty;
  assign extest   = (t_q.ir == jbd_pkg::OP_EXTEST);

  // Pin reset passes the two-flop mclk synchronizer; register reset comes from a tck flip-flop
  assign chipReset = ~t2m.extRstN | t_q.rstReg;

  always_comb begin
    for (int i = 0; i < jbd_pkg::PINS; i++) begin
      if (chipReset) begin
        pinOe[i]  = 1'b0;
        pinOut[i] = 1'b0;
      end else if (extest) begin
        pinOe[i]  = bsUpd[i*jbd_pkg::PIN_CELLS+jbd_pkg::CELL_CTRL];
        pinOut[i] = bsUpd[i*jbd_pkg::PIN_CELLS+jbd_pkg::CELL_OUT];
      end else begin
        pinOe[i]  = core.oe[i];
        pinOut[i] = core.out[i];
      end
    end
    for (int k = 0; k < jbd_pkg::ANA; k++) begin
      anaOut[k] = extest ? bsUpd[jbd_pkg::ANA_BASE+k] : core.ana[k];
    end
  end

endmodule : jbd_top

// ---- rtl/jbd_pkg.sv ----
package jbd_pkg;

  // Instruction register
  localparam int         IR_W       = 4;
  localparam logic [3:0] OP_EXTEST  = 4'h0;
  localparam logic [3:0] OP_IDCODE  = 4'h1;
  localparam logic [3:0] OP_SAMPLE  = 4'h2;
  localparam logic [3:0] OP_CHIPRST = 4'hC;
  localparam logic [3:0] OP_BYPASS  = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // Identification fields, values arbitrary
  localparam int          ID_W       = 32;
  localparam logic [3:0]  ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART    = 16'h5A5A;
  localparam logic [10:0] ID_MANUF   = 11'h2A6;
  localparam logic        ID_MARKER  = 1'b1;

  // Boundary chain layout
  localparam int PINS      = 8;
  localparam int ANA       = 2;
  localparam int PIN_CELLS = 3;
  localparam int CELL_IN   = 0;
  localparam int CELL_OUT  = 1;
  localparam int CELL_CTRL = 2;
  localparam int ANA_BASE  = PINS * PIN_CELLS;
  localparam int BS_LEN    = ANA_BASE + ANA;

  // Debug byte register
  localparam int         DB_W      = 8;
  localparam int         DIRTY_BIT = 7;
  localparam logic [7:0] DB_RESET  = 8'h00;

  // Nonvolatile bits, 1 means programmed
  localparam logic       NV_RESET     = 1'b0;
  localparam logic [1:0] PROG_DBGFUSE = 2'h0;
  localparam logic [1:0] PROG_LOCK1   = 2'h1;
  localparam logic [1:0] PROG_LOCK2   = 2'h2;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jbd_tap_t;

  typedef struct packed {
    logic            sel;
    logic            wr;
    logic            rd;
    logic [DB_W-1:0] wdata;
  } jbd_io_req_t;

  typedef struct packed {
    logic       req;
    logic [1:0] target;
    logic       value;
    logic       erase;
  } jbd_prog_t;

  typedef struct packed {
    logic [PINS-1:0] out;
    logic [PINS-1:0] oe;
    logic [ANA-1:0]  ana;
  } jbd_pins_t;

  // Main clock to test clock
  typedef struct packed {
    logic              rst;
    logic              portEn;
    logic              portDis;
    logic              dirty;
    logic [DB_W-1:0]   dbyte;
    logic [BS_LEN-1:0] cap;
  } jbd_m2t_t;

  // Test clock to main clock
  typedef struct packed {
    logic clrTgl;
    logic grant;
    logic extRstN;
  } jbd_t2m_t;

endpackage : jbd_pkg

// ---- rtl/jbd_sync.sv ----
`timescale 1ns/10ps
module jbd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jbd_sync_st_t;

  jbd_sync_st_t st_q;
  jbd_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule : jbd_sync

// ---- rtl/jbd_bscan.sv ----
`timescale 1ns/10ps
module jbd_bscan #(
  parameter int LEN = 1
) (
  input  wire logic           tck,
  input  wire logic           rst,
  input  wire logic           capture,
  input  wire logic           shift,
  input  wire logic           update,
  input  wire logic           tdi,
  input  wire logic [LEN-1:0] capData,
  output logic                so,
  output logic      [LEN-1:0] upd
);

  typedef struct packed {
    logic [LEN-1:0] sh;
    logic [LEN-1:0] up;
  } jbd_bscan_st_t;

  jbd_bscan_st_t st_q;
  jbd_bscan_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (capture) begin
      st_d.sh = capData;
    end else if (shift) begin
      st_d.sh = {tdi, st_q.sh[LEN-1:1]};
    end
    if (update) begin
      st_d.up = st_q.sh;
    end
  end

  always_ff @(posedge tck) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign so  = st_q.sh[0];
  assign upd = st_q.up;

endmodule : jbd_bscan

// ---- verif/jbd_chk.sv ----
`timescale 1ns/10ps
module jbd_chk (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       tck,
  input wire logic                       tms,
  input wire logic                       tdoOe,
  input wire logic                       extResetN,
  input wire logic                       testPortDisableBit,
  input wire jbd_pkg::jbd_io_req_t       ioReq,
  input wire logic                       stdIoWr,
  input wire logic [jbd_pkg::DB_W-1:0]   stdIoWdata,
  input wire jbd_pkg::jbd_prog_t         prog,
  input wire logic                       debugEnableFuse,
  input wire logic                       lockBitOne,
  input wire logic                       lockBitTwo,
  input wire logic [jbd_pkg::PINS-1:0]   pinOe,
  input wire logic                       chipReset
);
  sequence pinHeldLow;
    !extResetN [*4];
  endsequence

  sequence portOff;
    testPortDisableBit [*5];
  endsequence

  pin_float_a: assert property (@(posedge mclk)
    chipReset |-> pinOe == '0) else $error("pins driven in reset");
  pin_reset_a: assert property (@(posedge mclk) disable iff (rst)
    pinHeldLow |-> chipReset) else $error("reset pin ignored");
  std_write_a: assert property (@(posedge mclk) disable iff (rst)
    ioReq.sel && ioReq.wr && !debugEnableFuse |=>
    stdIoWr && stdIoWdata == $past(ioReq.wdata))
    else $error("standard write lost");
  no_std_a: assert property (@(posedge mclk) disable iff (rst)
    !(ioReq.sel && ioReq.wr) |=> !stdIoWr) else $error("stray write");
  lock_erase_a: assert property (@(posedge mclk) disable iff (rst)
    prog.erase |=> !lockBitOne && !lockBitTwo) else $error("erase failed");
  fuse_refuse_a: assert property (@(posedge mclk) disable iff (rst)
    prog.req && !prog.erase && prog.target == jbd_pkg::PROG_DBGFUSE &&
    (lockBitOne || lockBitTwo) && !debugEnableFuse |=> !debugEnableFuse)
    else $error("fuse set while locked");
  lock_hold_a: assert property (@(posedge mclk) disable iff (rst)
    lockBitOne && !prog.erase |=> lockBitOne) else $error("lock lost");
  lock_set_a: assert property (@(posedge mclk) disable iff (rst)
    prog.req && !prog.erase && prog.target == jbd_pkg::PROG_LOCK1 &&
    prog.value |=> lockBitOne) else $error("lock not set");
  port_off_a: assert property (@(posedge tck) disable iff (rst)
    portOff |-> !tdoOe) else $error("port active while disabled");
  shift_entry_a: assert property (@(posedge tck) disable iff (rst)
    $rose(tdoOe) |-> $past(tms) == 1'b0) else $error("bad shift entry");
endmodule : jbd_chk

bind jbd_top jbd_chk i_jbd_chk (.mclk, .rst, .tck, .tms, .tdoOe,
  .extResetN, .testPortDisableBit, .ioReq, .stdIoWr, .stdIoWdata, .prog,
  .debugEnableFuse, .lockBitOne, .lockBitTwo, .pinOe, .chipReset);

// ---- verif/jbd_ctl.sv ----
`timescale 1ns/10ps
module jbd_ctl (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      dbgGrant,
  output logic      dbgClearDirty,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    dbgGrant = 1'b0;
    dbgClearDirty = 1'b0;
  end

  // One test clock; tdo taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #32 o = tdo;
    tck = 1'b1;
    #32 tck = 1'b0;
  endtask : step

  // From idle through capture, shift and update back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    tdi = ~tdi;
  endtask : scan

  task automatic idle(input int n);
    logic o;
    repeat (n) step(1'b0, 1'b0, o);
  endtask : idle

  task automatic reset5;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : reset5

  task automatic clearDirty;
    logic o;
    dbgClearDirty = 1'b1;
    step(1'b0, 1'b0, o);
    dbgClearDirty = 1'b0;
  endtask : clearDirty
endmodule : jbd_ctl

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic                 mclk, rst, tck, tms, tdi, tdo, tdoOe, extResetN;
  logic                 testPortEnableFuse, testPortDisableBit, chipReset;
  logic                 stdIoWr, stdIoRd, debugEnableFuse, lockBitOne;
  logic                 lockBitTwo, dbgGrant, dbgClearDirty, dbgDirty;
  logic [7:0]           ioRdata, stdIoWdata, dbgByte, pinIn, pinOut, pinOe;
  logic [7:0]           pOut, pOe;
  logic [1:0]           anaOut;
  logic [31:0]          r, pre, mask, expIn, idCode;
  jbd_pkg::jbd_io_req_t ioReq;
  jbd_pkg::jbd_prog_t   prog;
  jbd_pkg::jbd_pins_t   core;
  int                   errors, samples_checked, cycles;

  jbd_top i_jbd_top (.mclk, .rst, .tck, .tms, .tdi, .tdo, .tdoOe, .extResetN,
    .testPortEnableFuse, .testPortDisableBit, .ioReq, .ioRdata, .stdIoWr,
    .stdIoRd, .stdIoWdata, .prog, .debugEnableFuse, .lockBitOne, .lockBitTwo,
    .dbgGrant, .dbgClearDirty, .dbgByte, .dbgDirty, .core, .pinIn, .pinOut,
    .pinOe, .anaOut, .chipReset);
  jbd_ctl i_jbd_ctl (.tck, .tms, .tdi, .dbgGrant, .dbgClearDirty, .tdo);

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      test_done;
    end
  end

  task automatic test_done;
    $display("errors %0d, samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cpu(input logic w, input logic [7:0] d);
    @(posedge mclk);
    ioReq <= '{sel: 1'b1, wr: w, rd: ~w, wdata: d};
    @(posedge mclk);
    ioReq <= '0;
    #1;
  endtask : cpu

  task automatic pg(input logic [1:0] t, input logic v, input logic e);
    @(posedge mclk);
    prog <= '{req: ~e, target: t, value: v, erase: e};
    @(posedge mclk);
    prog <= '0;
    #1;
  endtask : pg

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    extResetN = 1'b1;
    testPortEnableFuse = 1'b1;
    testPortDisableBit = 1'b0;
    ioReq = '0;
    prog = '0;
    core = '{out: 8'hC3, oe: 8'hF0, ana: 2'h1};
    pinIn = 8'h96;
    pOut = 8'h5A;
    pOe = 8'h3C;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    idCode = {jbd_pkg::ID_VERSION, jbd_pkg::ID_PART, jbd_pkg::ID_MANUF,
              jbd_pkg::ID_MARKER};
    pre = '0;
    mask = '0;
    expIn = '0;
    for (int i = 0; i < 8; i++) begin
      pre[3*i+1] = pOut[i];
      pre[3*i+2] = pOe[i];
      mask[3*i] = 1'b1;
      expIn[3*i] = pinIn[i];
    end
    pre[25:24] = 2'h2;
    i_jbd_ctl.reset5;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    i_jbd_ctl.reset5;
    i_jbd_ctl.scan(1'b0, 32, 32'h0, r);
    chk(r, idCode);
    i_jbd_ctl.scan(1'b1, 4, {28'h0, jbd_pkg::OP_BYPASS}, r);
    chk(r, {28'h0, jbd_pkg::IR_CAPTURE});
    i_jbd_ctl.scan(1'b0, 2, 32'h3, r);
    chk(r, 32'h2);
    i_jbd_ctl.scan(1'b1, 4, {28'h0, jbd_pkg::OP_CHIPRST}, r);
    i_jbd_ctl.scan(1'b0, 1, 32'h1, r);
    chk({r[0], chipReset, pinOe}, {2'b01, 8'h00});
    i_jbd_ctl.scan(1'b0, 1, 32'h0, r);
    chk({r[0], chipReset, pinOe}, {2'b10, core.oe});
    @(posedge mclk) extResetN <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({chipReset, pinOe}, 9'h100);
    @(posedge mclk) extResetN <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(chipReset, 1'b0);
    // Safe values go in before the first drive
    i_jbd_ctl.scan(1'b1, 4, {28'h0, jbd_pkg::OP_SAMPLE}, r);
    i_jbd_ctl.scan(1'b0, 26, pre, r);
    chk(r & mask, expIn);
    chk({pinOut, pinOe, anaOut}, {core.out, core.oe, core.ana});
    i_jbd_ctl.scan(1'b1, 4, {28'h0, jbd_pkg::OP_EXTEST}, r);
    chk({pinOut, pinOe, anaOut}, {pOut, pOe, 2'h2});
    i_jbd_ctl.scan(1'b0, 26, pre, r);
    chk(r & mask, expIn);
    for (int k = 0; k < 2; k++) begin
      i_jbd_ctl.scan(1'b1, 4, {28'h0, jbd_pkg::OP_EXTEST}, r);
      @(posedge mclk);
      testPortEnableFuse <= 1'(k == 0);
      testPortDisableBit <= 1'(k == 0);
      i_jbd_ctl.idle(6);
      chk(pinOut, core.out);
      @(posedge mclk);
      testPortEnableFuse <= 1'b1;
      testPortDisableBit <= 1'b0;
      i_jbd_ctl.idle(6);
      i_jbd_ctl.scan(1'b0, 32, 32'h0, r);
      chk(r, idCode);
    end
    pg(jbd_pkg::PROG_DBGFUSE, 1'b1, 1'b0);
    chk(debugEnableFuse, 1'b1);
    cpu(1'b1, 8'hA7);
    chk({stdIoWr, stdIoWdata}, 9'h1A7);
    i_jbd_ctl.dbgGrant = 1'b1;
    repeat (4) @(posedge mclk);
    cpu(1'b0, 8'h00);
    chk({stdIoRd, ioRdata}, 9'h000);
    cpu(1'b1, 8'h35);
    chk(stdIoWr, 1'b0);
    cpu(1'b0, 8'h00);
    chk(ioRdata, 8'hB5);
    i_jbd_ctl.idle(5);
    chk({dbgDirty, dbgByte}, 9'h135);
    i_jbd_ctl.clearDirty;
    repeat (4) @(posedge mclk);
    cpu(1'b0, 8'h00);
    chk(ioRdata, 8'h35);
    pg(jbd_pkg::PROG_LOCK2, 1'b1, 1'b0);
    pg(jbd_pkg::PROG_DBGFUSE, 1'b0, 1'b0);
    cpu(1'b1, 8'h11);
    chk({stdIoWr, stdIoWdata}, 9'h111);
    cpu(1'b0, 8'h00);
    chk({stdIoRd, stdIoWr}, 2'b10);
    pg(jbd_pkg::PROG_DBGFUSE, 1'b1, 1'b0);
    chk({debugEnableFuse, lockBitOne, lockBitTwo}, 3'b001);
    pg(jbd_pkg::PROG_LOCK1, 1'b1, 1'b0);
    pg(jbd_pkg::PROG_DBGFUSE, 1'b0, 1'b1);
    chk({lockBitOne, lockBitTwo}, 2'b00);
    pg(jbd_pkg::PROG_DBGFUSE, 1'b1, 1'b0);
    chk(debugEnableFuse, 1'b1);
    test_done;
  end
endmodule : testbench
